// [design/raw_hazard_stall_control.sv]
// Purpose: Detects read-after-write hazards between the executing and prefetched
//          instruction and inserts stall and program-space-view wait cycles.
// Assumes: Instruction descriptors come from logic on the same clock; cur_instr.valid
//          marks a new instruction that may issue when hold is low.
// Notes: Registers are reached over AXI4-Lite.
`timescale 1ns/1ps
module raw_hazard_stall_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire hazard_pkg::instr_t cur_instr,
   input wire hazard_pkg::instr_t pre_instr,
   input wire logic repeat_active,
   input wire logic irq_on_current,
   input wire hazard_pkg::axi_req_t axi_req,
   output hazard_pkg::axi_rsp_t axi_rsp,
   output logic hold,
   output logic hazard_stall,
   output logic psv_redirect,
   output logic [22:0] psv_prog_addr
);
   import hazard_pkg::*;

   typedef struct packed {
      axi_rsp_t rsp;
      logic aw_have;
      logic [AW-1:0] aw_addr;
      logic w_have;
      logic [DW-1:0] w_data;
      logic [3:0] w_strb;
      logic [15:0] core_control;
      logic [7:0] psv_page;
      logic [15:0] repeat_loop_count;
      logic [15:0] stall_count;
      logic [1:0] wait_cnt;
      logic hold;
      logic haz_stall;
      logic psv_redir;
      logic [22:0] prog_addr;
   } state_t;

   state_t q, d;
   operand_t src;
   operand_t dst;
   logic src_ind;
   logic haz;
   logic program_space_view;
   logic issue;

   // Return and branch instructions never write a register.
   always_comb begin
      dst = cur_instr.dst;
      unique case (cur_instr.kind)
         K_CALL: begin
            dst.mode = AM_IND_MOD;
            dst.idx = STACK_REG;
         end
         K_RETURN: dst.mode = AM_NONE;
         K_BRANCH: dst.mode = AM_NONE;
         K_RET_LITERAL: dst = cur_instr.dst;
         K_NORMAL: dst = cur_instr.dst;
         default: dst.mode = AM_NONE;
      endcase
   end

   // In a repeat loop the prefetch never moves, so the instruction meets itself.
   assign src = repeat_active ? cur_instr.src : pre_instr.src;
   assign src_ind = (src.mode == AM_INDIRECT) || (src.mode == AM_IND_MOD);

   // A working register is mapped at byte address twice its index.
   always_comb begin
      haz = 1'b0;
      if (src_ind) begin
         if ((dst.mode == AM_DIRECT) && (dst.idx == src.idx)) begin
            haz = 1'b1;
         end
         if ((dst.mode == AM_IND_MOD) && (dst.idx == src.idx)) begin
            haz = 1'b1;
         end
         if (((dst.mode == AM_INDIRECT) || (dst.mode == AM_IND_MOD))
             && (dst.ea == {11'h000, src.idx, 1'b0})) begin
            haz = 1'b1;
         end
      end
      if (irq_on_current) begin
         haz = 1'b0;
      end
   end

   assign program_space_view = q.core_control[PSV_ENABLE_BIT] && src_ind
                && src.ea[PSV_WINDOW_BIT];
   assign issue = cur_instr.valid && (q.wait_cnt == 2'h0);

   always_comb begin
      logic [1:0] extra;
      logic [DW-1:0] rd;
      logic [1:0] rr;
      extra = 2'h0;
      rd = '0;
      rr = RESP_OKAY;
      d = q;
      // Stall and view cycles simply add before the prefetched instruction runs.
      if (issue) begin
         extra = (haz ? HAZARD_CYCLES : 2'h0) + (program_space_view ? PSV_EXTRA_CYCLES : 2'h0);
         d.wait_cnt = extra;
         d.haz_stall = haz;
         d.psv_redir = program_space_view;
         if (program_space_view) begin
            d.prog_addr = {q.psv_page, src.ea[14:0]};
         end
         if (haz) begin
            d.stall_count = q.stall_count + 16'h0001;
         end
      end else begin
         d.haz_stall = 1'b0;
         if (q.wait_cnt != 2'h0) begin
            d.wait_cnt = q.wait_cnt - 2'h1;
         end
      end
      if (d.wait_cnt == 2'h0) begin
         d.psv_redir = 1'b0;
      end
      d.hold = (d.wait_cnt != 2'h0);

      // Write address and data are taken in either order.
      if (axi_req.awvalid && q.rsp.awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && q.rsp.wready) begin
         d.w_have = 1'b1;
         d.w_data = axi_req.wdata;
         d.w_strb = axi_req.wstrb;
      end
      if (q.rsp.bvalid && axi_req.bready) begin
         d.rsp.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = RESP_OKAY;
         unique case (q.aw_addr)
            OFS_CORE_CONTROL: begin
               if (q.w_strb[0]) begin
                  d.core_control[7:0] = q.w_data[7:0] & CORE_CONTROL_MASK[7:0];
               end
               if (q.w_strb[1]) begin
                  d.core_control[15:8] = q.w_data[15:8] & CORE_CONTROL_MASK[15:8];
               end
            end
            OFS_PSV_PAGE: begin
               if (q.w_strb[0]) begin
                  d.psv_page = q.w_data[7:0];
               end
            end
            OFS_REPEAT_COUNT: begin
               if (q.w_strb[0]) begin
                  d.repeat_loop_count[7:0] = q.w_data[7:0];
               end
               if (q.w_strb[1]) begin
                  d.repeat_loop_count[15:8] = q.w_data[15:8];
               end
            end
            OFS_STALL_STATUS: d.rsp.bresp = RESP_OKAY;
            default: d.rsp.bresp = RESP_SLVERR;
         endcase
      end
      d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
      d.rsp.wready = !d.w_have && !d.rsp.bvalid;

      if (q.rsp.rvalid && axi_req.rready) begin
         d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && q.rsp.arready) begin
         unique case (axi_req.araddr)
            OFS_CORE_CONTROL: rd = {16'h0000, q.core_control & CORE_CONTROL_MASK};
            OFS_PSV_PAGE: rd = {24'h000000, q.psv_page};
            OFS_REPEAT_COUNT: rd = {16'h0000, q.repeat_loop_count};
            OFS_STALL_STATUS: rd = {13'h0000, q.psv_redir, q.haz_stall, q.hold, q.stall_count};
            default: rr = RESP_SLVERR;
         endcase
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata = rd;
         d.rsp.rresp = rr;
      end
      d.rsp.arready = !d.rsp.rvalid;

      if (!rst_n) begin
         d = '0;
         d.core_control = CORE_CONTROL_RST;
         d.psv_page = PSV_PAGE_RST;
         d.repeat_loop_count = q.repeat_loop_count;
         d.rsp.awready = 1'b1;
         d.rsp.wready = 1'b1;
         d.rsp.arready = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign axi_rsp = q.rsp;
   assign hold = q.hold;
   assign hazard_stall = q.haz_stall;
   assign psv_redirect = q.psv_redir;
   assign psv_prog_addr = q.prog_addr;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic same_reg;
   logic mapped;
   assign same_reg = cur_instr.dst.idx == src.idx;
   assign mapped = cur_instr.dst.ea == {11'h000, src.idx, 1'b0};

   chk_direct_direct: assert property (
      issue && !program_space_view && cur_instr.kind == K_NORMAL && cur_instr.dst.mode == AM_DIRECT
      && src.mode == AM_DIRECT |=> !hazard_stall && !hold)
      else $error("direct read after direct write stalled");
   chk_direct_ind: assert property (
      issue && !irq_on_current && cur_instr.kind == K_NORMAL
      && cur_instr.dst.mode == AM_DIRECT && same_reg && src_ind |=> hazard_stall && hold)
      else $error("indirect read after direct write did not stall");
   chk_ptr_plain: assert property (
      issue && cur_instr.kind == K_NORMAL && cur_instr.dst.mode == AM_INDIRECT
      && !mapped |=> !hazard_stall)
      else $error("unmodified pointer write stalled");
   chk_mapped_write: assert property (
      issue && !irq_on_current && cur_instr.kind == K_NORMAL
      && cur_instr.dst.mode == AM_INDIRECT && mapped && src_ind |=> hazard_stall)
      else $error("write to mapped register did not stall");
   chk_mod_ind: assert property (
      issue && !irq_on_current && cur_instr.kind == K_NORMAL
      && cur_instr.dst.mode == AM_IND_MOD && same_reg && src_ind |=> hazard_stall)
      else $error("modified pointer reuse did not stall");
   chk_mod_direct: assert property (
      issue && cur_instr.kind == K_NORMAL && cur_instr.dst.mode == AM_IND_MOD
      && src.mode == AM_DIRECT |=> !hazard_stall)
      else $error("direct read after pointer update stalled");
   chk_call_stack: assert property (
      issue && !irq_on_current && cur_instr.kind == K_CALL && src_ind
      && src.idx == STACK_REG |=> hazard_stall)
      else $error("call did not stall stack pointer user");
   chk_flow_none: assert property (
      issue && (cur_instr.kind == K_RETURN || cur_instr.kind == K_BRANCH) && !mapped
      |=> !hazard_stall)
      else $error("return or branch caused a stall");
   chk_stall_one: assert property (
      issue && haz && !program_space_view |=> hold ##1 !hold)
      else $error("hazard stall not exactly one cycle");
   chk_psv_bound: assert property (
      issue && program_space_view && !haz |=> psv_redirect && hold ##1 hold ##1 !hold)
      else $error("view read exceeded three cycles");
   chk_psv_add: assert property (
      issue && program_space_view && haz |=> hold [*3] ##1 !hold)
      else $error("view and stall cycles did not add");
   chk_irq_drop: assert property (
      issue && irq_on_current && !program_space_view |=> !hazard_stall && !hold)
      else $error("stall kept after interrupt");

   // The checks below guard the flow-change, loop, view and register paths.
   // They watch registered outputs and the q.stall_count and q.core_control registers,
   // so that a broken counter or mask shows up there and not only in the hazard decode.
   chk_return_with_literal_stall: assert property (
      issue && !irq_on_current && cur_instr.kind == K_RET_LITERAL
      && cur_instr.dst.mode == AM_DIRECT && same_reg && src_ind |=> hazard_stall)
      else $error("return with literal did not stall");

   chk_repeat_self: assert property (
      issue && repeat_active && !irq_on_current && cur_instr.kind == K_NORMAL
      && cur_instr.dst.mode == AM_DIRECT && cur_instr.src.mode == AM_INDIRECT
      && cur_instr.dst.idx == cur_instr.src.idx |=> hazard_stall)
      else $error("repeated instruction not checked against itself");

   chk_loop_end: assert property (
      issue && !repeat_active && !irq_on_current && cur_instr.kind == K_NORMAL
      && cur_instr.dst.mode == AM_DIRECT && pre_instr.src.mode == AM_INDIRECT
      && cur_instr.dst.idx == pre_instr.src.idx |=> hazard_stall)
      else $error("prefetched instruction not checked");

   chk_view_addr: assert property (
      issue && program_space_view |=> psv_prog_addr == {$past(q.psv_page), $past(src.ea[14:0])})
      else $error("view address wrong");

   chk_view_off: assert property (
      issue && !q.core_control[PSV_ENABLE_BIT] |=> !psv_redirect)
      else $error("view redirect while disabled");

   chk_hold_refuse: assert property (
      hold |=> !hazard_stall)
      else $error("issue taken during hold");

   chk_hold_fetch: assert property (
      hold |=> $stable(q.stall_count))
      else $error("stall counted during hold");

   chk_stall_count: assert property (
      issue && haz |=> q.stall_count == $past(q.stall_count) + 16'h0001)
      else $error("stall count not advanced");

   chk_pulse_one: assert property (
      hazard_stall |=> !hazard_stall)
      else $error("stall pulse longer than one cycle");

   chk_stall_hold: assert property (
      hazard_stall |-> hold)
      else $error("stall without hold");

   chk_ctrl_mask: assert property (
      q.core_control[15:11] == 5'h00)
      else $error("unimplemented control bits set");

   chk_read_upper: assert property (
      axi_rsp.rvalid |-> axi_rsp.rdata[31:19] == 13'h0000)
      else $error("unused read bits not zero");

   chk_slverr_data: assert property (
      axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == '0)
      else $error("refused read returned data");

   chk_redirect_hold: assert property (
      psv_redirect |-> hold)
      else $error("view redirect outside hold");

   chk_hold_len: assert property (
      $rose(hold) |-> ##[1:3] !hold)
      else $error("hold longer than three cycles");

   chk_irq_view: assert property (
      issue && irq_on_current && program_space_view |=> !hazard_stall && psv_redirect)
      else $error("interrupt dropped view cycles");

   chk_flow_hold: assert property (
      issue && (cur_instr.kind == K_RETURN || cur_instr.kind == K_BRANCH)
      && !program_space_view |=> !hold)
      else $error("return or branch held the fetch");

   chk_ptr_hold: assert property (
      issue && cur_instr.kind == K_NORMAL && cur_instr.dst.mode == AM_INDIRECT
      && !mapped && !program_space_view |=> !hold)
      else $error("unmodified pointer write held the fetch");

   chk_mod_dir_hold: assert property (
      issue && cur_instr.kind == K_NORMAL && cur_instr.dst.mode == AM_IND_MOD
      && src.mode == AM_DIRECT |=> !hold)
      else $error("direct read after pointer update held");

   chk_mapped_mod: assert property (
      issue && !irq_on_current && cur_instr.kind == K_NORMAL
      && cur_instr.dst.mode == AM_IND_MOD && mapped && src_ind |=> hazard_stall)
      else $error("mapped write through pointer did not stall");

   chk_back_to_back: assert property (
      issue && !haz && !program_space_view |=> !hold)
      else $error("clean issue held the fetch");

   chk_stall_flag: assert property (
      issue && haz && program_space_view |=> hazard_stall && psv_redirect)
      else $error("view and stall flags not both raised");

   cov_hazard: cover property (issue && haz);
   cov_psv_hazard: cover property (issue && program_space_view && haz);
   cov_repeat: cover property (issue && repeat_active && haz);
   cov_irq: cover property (issue && irq_on_current && src_ind);
endmodule // raw_hazard_stall_control

// [inc/hazard_pkg.sv]
// Purpose: Shared types and constants for the read-after-write stall controller.
// Assumes: One 40 MHz instruction clock, synchronous active-low reset.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
// Overview of operation
// - Direct write, direct read: no stall.
// - Direct write, indirect source read: stall.
// - Unmodified pointer write, same register: no stall.
// - Write to register's mapped address: stall.
// - Modified pointer, indirect source read: stall.
// - Modified pointer, direct source read: no stall.
// - Calls write stack pointer; stall its users.
// - Returns only read: never stall.
// - Return-with-literal writes register: normal check.
// - Jumps and branches never stall.
// - Loops unchanged except added stall cycles.
// - Repeat loop compares instruction with itself.
// - Loop end uses whatever was prefetched.
// - View bit redirects upper window reads.
// - Redirected read finishes within three cycles.
// - View cycles and hazard stall add.
// - Unimplemented register bits read zero.
// - Loop counters are not reset.
// - Hazard inserts exactly one stall cycle.
// - Stall holds counter, fetch and data space.
// - Interrupt on first instruction drops stall.
package hazard_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam logic [AW-1:0] OFS_CORE_CONTROL = 8'h00;
   localparam logic [AW-1:0] OFS_PSV_PAGE = 8'h04;
   localparam logic [AW-1:0] OFS_REPEAT_COUNT = 8'h08;
   localparam logic [AW-1:0] OFS_STALL_STATUS = 8'h0C;
   localparam logic [15:0] CORE_CONTROL_RST = 16'h0020;
   localparam logic [15:0] CORE_CONTROL_MASK = 16'h07FF;
   localparam int PSV_ENABLE_BIT = 2;
   localparam int PSV_WINDOW_BIT = 15;
   localparam logic [7:0] PSV_PAGE_RST = 8'h00;
   localparam logic [3:0] STACK_REG = 4'hF;
   localparam logic [1:0] PSV_EXTRA_CYCLES = 2'h2;
   localparam logic [1:0] HAZARD_CYCLES = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      AM_NONE = 2'b00,
      AM_DIRECT = 2'b01,
      AM_INDIRECT = 2'b10,
      AM_IND_MOD = 2'b11
   } addr_mode_t;

   typedef enum logic [2:0] {
      K_NORMAL = 3'b000,
      K_CALL = 3'b001,
      K_RETURN = 3'b010,
      K_RET_LITERAL = 3'b011,
      K_BRANCH = 3'b100
   } instr_kind_t;

   typedef struct packed {
      addr_mode_t mode;
      logic [3:0] idx;
      logic [15:0] ea;
   } operand_t;

   typedef struct packed {
      logic valid;
      instr_kind_t kind;
      operand_t dst;
      operand_t src;
   } instr_t;

   typedef struct packed {
      logic awvalid;
      logic [AW-1:0] awaddr;
      logic wvalid;
      logic [DW-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AW-1:0] araddr;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DW-1:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;
endpackage

// [sim/tb.sv]
// Purpose: Self-checking bench for the read-after-write stall controller.
// Assumes: Hold lengths and register offsets as the package defines them.
// Notes: Random instructions come from an xorshift generator with a fixed seed.
`timescale 1ns/1ps
module tb;
   import hazard_pkg::*;
   logic clk, rst_n, repeat_active, irq_on_current, hold, hazard_stall, psv_redirect;
   instr_t cur_instr, pre_instr, c, p;
   axi_req_t axi_req;
   axi_rsp_t axi_rsp;
   logic [22:0] psv_prog_addr;
   int fail_count = 0;
   int total_checks = 0;
   int exp_cnt = 0;
   int i;
   logic [31:0] seed = 32'h779C;
   logic [31:0] r, rd;
   logic [3:0] di, si;
   logic [1:0] rs;

   raw_hazard_stall_control i_dut (
      .clk(clk), .rst_n(rst_n), .cur_instr(cur_instr), .pre_instr(pre_instr),
      .repeat_active(repeat_active), .irq_on_current(irq_on_current),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .hold(hold), .hazard_stall(hazard_stall),
      .psv_redirect(psv_redirect), .psv_prog_addr(psv_prog_addr));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic instr_t mk(instr_kind_t k, addr_mode_t dm, logic [3:0] di,
      logic [15:0] de, addr_mode_t sm, logic [3:0] si, logic [15:0] se);
      return '{1'b1, k, '{dm, di, de}, '{sm, si, se}};
   endfunction

   // Only an indirect source can be hurt by a pending register write.
   function automatic logic haz(instr_t c, instr_t p, logic rep, logic irq);
      operand_t s;
      s = rep ? c.src : p.src;
      if (irq || c.kind == K_RETURN || c.kind == K_BRANCH) return 1'b0;
      if (s.mode != AM_INDIRECT && s.mode != AM_IND_MOD) return 1'b0;
      return ((c.dst.mode == AM_DIRECT || c.dst.mode == AM_IND_MOD) && c.dst.idx == s.idx)
         || (c.dst.mode[1] && c.dst.ea == {11'h000, s.idx, 1'b0});
   endfunction

   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic issue(instr_t c, instr_t p, logic rep, logic irq, logic view);
      int n;
      logic h;
      h = haz(c, p, rep, irq);
      cur_instr <= c;
      pre_instr <= p;
      repeat_active <= rep;
      irq_on_current <= irq;
      @(posedge clk);
      cur_instr.valid <= 1'b0;
      @(negedge clk);
      chk(hazard_stall, h, "stall pulse");
      chk(psv_redirect, view, "view redirect");
      n = 0;
      while (hold === 1'b1 && n < 8) begin
         n++;
         @(negedge clk);
      end
      chk(n, h + 2 * view, "hold cycles");
      exp_cnt += h;
      @(posedge clk);
   endtask

   task automatic tcase(instr_kind_t k, addr_mode_t dm, logic [3:0] di, logic [15:0] de,
      addr_mode_t sm, logic [3:0] si);
      issue(mk(k, dm, di, de, AM_NONE, 0, 0), mk(K_NORMAL, AM_NONE, 0, 0, sm, si, 0), 0, 0, 0);
   endtask

   task automatic wchk(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      int n;
      logic aw, w, b;
      b = 1'b0;
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      for (n = 0; n < 40 && !b; n++) begin
         @(negedge clk);
         aw = axi_req.awvalid && axi_rsp.awready === 1'b1;
         w = axi_req.wvalid && axi_rsp.wready === 1'b1;
         b = axi_rsp.bvalid === 1'b1;
         rs = axi_rsp.bresp;
         @(posedge clk);
         if (aw) axi_req.awvalid <= 1'b0;
         if (w) axi_req.wvalid <= 1'b0;
      end
      axi_req.bready <= 1'b0;
      chk(b, 1'b1, "write answered");
      chk(rs, er, "write resp");
   endtask

   task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
      int n;
      logic ar, v;
      v = 1'b0;
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      for (n = 0; n < 40 && !v; n++) begin
         @(negedge clk);
         ar = axi_req.arvalid && axi_rsp.arready === 1'b1;
         v = axi_rsp.rvalid === 1'b1;
         rd = axi_rsp.rdata;
         rs = axi_rsp.rresp;
         @(posedge clk);
         if (ar) axi_req.arvalid <= 1'b0;
      end
      axi_req.rready <= 1'b0;
      chk(v, 1'b1, "read answered");
      chk(rd, e, "read data");
      chk(rs, er, "read resp");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #250000;
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      rst_n = 1'b0;
      repeat_active = 1'b0;
      irq_on_current = 1'b0;
      cur_instr = '0;
      pre_instr = '0;
      axi_req = '0;
      axi_req.wstrb = 4'hF;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(OFS_CORE_CONTROL, {16'h0000, CORE_CONTROL_RST}, RESP_OKAY);
      rchk(OFS_PSV_PAGE, 32'h0, RESP_OKAY);
      rchk(OFS_STALL_STATUS, 32'h0, RESP_OKAY);
      wchk(OFS_CORE_CONTROL, 32'hFFFFFFFF, RESP_OKAY);
      rchk(OFS_CORE_CONTROL, {16'h0000, CORE_CONTROL_MASK}, RESP_OKAY);
      wchk(OFS_CORE_CONTROL, 32'h20, RESP_OKAY);
      r = rnd();
      wchk(OFS_REPEAT_COUNT, {16'h0000, r[15:0]}, RESP_OKAY);
      rchk(OFS_REPEAT_COUNT, {16'h0000, r[15:0]}, RESP_OKAY);
      wchk(8'h10, 32'h1, RESP_SLVERR);
      rchk(8'h10, 32'h0, RESP_SLVERR);
      wchk(OFS_STALL_STATUS, 32'hFFFF, RESP_OKAY);
      $display("test registers done");
      tcase(K_NORMAL, AM_DIRECT, 2, 0, AM_DIRECT, 2);
      tcase(K_NORMAL, AM_DIRECT, 2, 0, AM_INDIRECT, 2);
      tcase(K_NORMAL, AM_DIRECT, 2, 0, AM_IND_MOD, 2);
      tcase(K_NORMAL, AM_INDIRECT, 2, 16'h0100, AM_INDIRECT, 2);
      tcase(K_NORMAL, AM_INDIRECT, 2, 16'h0004, AM_INDIRECT, 2);
      tcase(K_NORMAL, AM_INDIRECT, 2, 16'h0004, AM_IND_MOD, 2);
      tcase(K_NORMAL, AM_IND_MOD, 2, 16'h0100, AM_INDIRECT, 2);
      tcase(K_NORMAL, AM_IND_MOD, 2, 16'h0100, AM_IND_MOD, 2);
      tcase(K_NORMAL, AM_IND_MOD, 2, 16'h0100, AM_DIRECT, 2);
      tcase(K_CALL, AM_IND_MOD, 15, 16'h0800, AM_INDIRECT, 15);
      tcase(K_CALL, AM_IND_MOD, 15, 16'h0800, AM_INDIRECT, 3);
      tcase(K_RETURN, AM_DIRECT, 2, 0, AM_INDIRECT, 2);
      tcase(K_RET_LITERAL, AM_DIRECT, 2, 0, AM_INDIRECT, 2);
      tcase(K_BRANCH, AM_DIRECT, 2, 0, AM_INDIRECT, 2);
      c = mk(K_NORMAL, AM_DIRECT, 5, 0, AM_INDIRECT, 5, 0);
      p = mk(K_NORMAL, AM_NONE, 0, 0, AM_INDIRECT, 1, 0);
      issue(c, p, 1, 0, 0);
      issue(c, p, 0, 0, 0);
      c.src.idx = 1;
      issue(c, mk(K_NORMAL, AM_NONE, 0, 0, AM_INDIRECT, 5, 0), 0, 1, 0);
      $display("test corner cases done");
      for (i = 0; i < 200; i++) begin
         r = rnd();
         di = (r[1:0] == 2'h3) ? 4'hF : {2'h0, r[1:0]};
         si = (r[3:2] == 2'h3) ? 4'hF : {2'h0, r[3:2]};
         c = mk(instr_kind_t'(3'(r[6:4] % 5)), addr_mode_t'(r[8:7]), di,
            r[9] ? {11'h000, si, 1'b0} : 16'h0800, addr_mode_t'(r[11:10]), si, {1'b0, r[30:16]});
         if (c.kind == K_CALL) c.dst = '{AM_IND_MOD, 4'hF, 16'h0800};
         p = mk(K_NORMAL, AM_NONE, 0, 0, addr_mode_t'(r[13:12]), r[14] ? si : di, {1'b0, r[15:1]});
         issue(c, p, r[31], r[15] & r[3], 1'b0);
      end
      rchk(OFS_STALL_STATUS, exp_cnt, RESP_OKAY);
      $display("test random done");
      wchk(OFS_PSV_PAGE, 32'hAA, RESP_OKAY);
      wchk(OFS_CORE_CONTROL, 32'h24, RESP_OKAY);
      c = mk(K_NORMAL, AM_NONE, 0, 0, AM_INDIRECT, 2, 16'h8123);
      issue(c, c, 0, 0, 1);
      chk(psv_prog_addr, {8'hAA, 15'h0123}, "view address");
      c = mk(K_NORMAL, AM_IND_MOD, 2, 16'h0300, AM_INDIRECT, 2, 16'h8004);
      issue(c, c, 0, 0, 1);
      c.src.ea = 16'h0123;
      issue(c, c, 0, 0, 0);
      rchk(OFS_STALL_STATUS, exp_cnt, RESP_OKAY);
      $display("test view done");
      finish_test();
   end
endmodule // tb
